/* logic/miopc_top.sv */
// Machine I/O panel control: pedal, protection, jog, stop, lamps, lift, vacuum
`timescale 1ns/1ps
module miopc_top #(
    parameter logic [miopc_pkg::PRE_W-1:0] TICK_DIV =
        miopc_pkg::PRE_W'(miopc_pkg::MS_CYCLES),
    parameter logic [miopc_pkg::MS_CNT_W-1:0] HOLD_MS =
        miopc_pkg::MS_CNT_W'(miopc_pkg::PEDAL_HOLD_MS),
    parameter logic [miopc_pkg::MS_CNT_W-1:0] GAP_MS =
        miopc_pkg::MS_CNT_W'(miopc_pkg::PEDAL_GAP_MS),
    parameter logic [miopc_pkg::MS_CNT_W-1:0] FIN_MS =
        miopc_pkg::MS_CNT_W'(miopc_pkg::FINISH_MS)
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Panel inputs from pins; pedal, jog and stop active low; protect, alarms and spares active high
    input wire logic pedal_in_n_i,
    input wire logic protect_in_i,
    input wire logic jog_neg_n_i,
    input wire logic jog_pos_n_i,
    input wire logic stop_n_i,
    input wire logic [miopc_pkg::NUM_AXES-1:0] servo_alarm_in_i,
    input wire logic [miopc_pkg::NUM_SPARE-1:0] spare_in_i,
    // Configuration
    input wire logic protect_en_i,
    input wire logic red_en_i,
    input wire logic yellow_en_i,
    input wire logic green_en_i,
    input wire logic beep_en_i,
    input wire logic lift_io_en_i,
    input wire logic lift_sel_wheel_i,
    // Controller requests
    input wire logic job_done_i,
    input wire logic red_req_i,
    input wire logic yellow_req_i,
    input wire logic green_req_i,
    input wire logic beep_req_i,
    input wire logic knife_lift_req_i,
    input wire logic wheel_lift_req_i,
    input wire logic laser_req_i,
    input wire logic [miopc_pkg::NUM_ZONES-1:0] vacuum_zone_req_i,
    input wire logic vacuum_master_req_i,
    // Machine state and commands
    output logic [2:0] work_state_o,
    output logic start_cmd_o,
    output logic pause_cmd_o,
    output logic resume_cmd_o,
    output logic stop_cmd_o,
    output logic protected_o,
    output logic laser_on_o,
    output logic jog_neg_o,
    output logic jog_pos_o,
    output logic [miopc_pkg::NUM_AXES-1:0] servo_alarm_o,
    output logic [miopc_pkg::NUM_SPARE-1:0] spare_o,
    // Driven outputs
    output logic finish_out_o,
    output logic red_out_o,
    output logic yellow_out_o,
    output logic green_out_o,
    output logic beeper_out_o,
    output logic lift_out_o,
    output logic [miopc_pkg::NUM_ZONES-1:0] vacuum_zone_out_o,
    output logic vacuum_master_out_o
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    miopc_sync_if sif ();
    assign sif.raw = {spare_in_i, servo_alarm_in_i, stop_n_i, jog_pos_n_i,
                      jog_neg_n_i, protect_in_i, pedal_in_n_i};

    miopc_sync u_sync (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_r),
        .sif(sif)
    );

    miopc_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_r),
        .sif(sif)
    );

    logic pedal_low;
    logic prot_s;
    logic stop_low;
    assign pedal_low = !sif.synced[miopc_pkg::IDX_PEDAL];
    assign prot_s = sif.synced[miopc_pkg::IDX_PROT];
    assign stop_low = !sif.synced[miopc_pkg::IDX_STOP];

    ////////////////////////////////////////////////////////////////////////
    // Pedal qualification
    logic [miopc_pkg::MS_CNT_W-1:0] hold_r;
    logic [miopc_pkg::MS_CNT_W-1:0] gap_r;
    logic armed_r;
    logic gap_act_r;
    logic press_r;

    // Hold counter restarts whenever the pedal lifts; only one
    // acceptance per press, re-armed on release.
    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            hold_r <= '0;
            armed_r <= 1'b1;
            press_r <= 1'b0;
        end else begin
            press_r <= 1'b0;
            if (!pedal_low) begin
                hold_r <= '0; // RL1
                armed_r <= 1'b1;
            end else if (armed_r && sif.ms_tick) begin
                // One tick more than HOLD_MS: the first tick may come at
                // once, so only this count guarantees a full hold time
                if (hold_r == HOLD_MS) begin
                    armed_r <= 1'b0;
                    if (!gap_act_r) begin
                        press_r <= 1'b1; // RL1
                    end
                end else begin
                    hold_r <= hold_r + 1'b1; // RL1
                end
            end
        end
    end

    // Window after an accepted press; a press that begins while the window is
    // open is dropped even if its hold completes after the window closes
    logic start_in_gap_r;
    logic pedal_low_d_r;
    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            gap_r <= '0;
            gap_act_r <= 1'b0;
            start_in_gap_r <= 1'b0;
            pedal_low_d_r <= 1'b0;
        end else begin
            pedal_low_d_r <= pedal_low;
            if (pedal_low && !pedal_low_d_r) begin
                start_in_gap_r <= gap_act_r; // RL3
            end
            if (press_r) begin
                gap_act_r <= 1'b1;
                gap_r <= '0;
            end else if (gap_act_r && sif.ms_tick) begin
                // Extra tick keeps the window at least GAP_MS long
                if (gap_r == GAP_MS) begin
                    gap_act_r <= 1'b0;
                end else begin
                    gap_r <= gap_r + 1'b1;
                end
            end
        end
    end

    logic accept;
    assign accept = press_r && !start_in_gap_r; // RL3

    ////////////////////////////////////////////////////////////////////////
    // Work state machine
    miopc_pkg::miopc_state_type state_r;
    miopc_pkg::miopc_state_type state_nxt;
    logic prot_act;
    assign prot_act = protect_en_i && prot_s; // RL4 RL5

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            miopc_pkg::ST_IDLE: begin
                if (accept && !prot_act && !stop_low) begin
                    state_nxt = miopc_pkg::ST_RUN; // RL2
                end
            end
            miopc_pkg::ST_RUN: begin
                if (stop_low || job_done_i) begin
                    state_nxt = miopc_pkg::ST_IDLE; // RL7
                end else if (prot_act || accept) begin
                    state_nxt = miopc_pkg::ST_PAUSE; // RL2 RL5
                end
            end
            miopc_pkg::ST_PAUSE: begin
                if (stop_low) begin
                    state_nxt = miopc_pkg::ST_IDLE; // RL7
                end else if (accept && !prot_act) begin
                    state_nxt = miopc_pkg::ST_RUN; // RL2
                end
            end
            default: state_nxt = miopc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= miopc_pkg::ST_IDLE;
            start_cmd_o <= 1'b0;
            pause_cmd_o <= 1'b0;
            resume_cmd_o <= 1'b0;
            stop_cmd_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_cmd_o <= state_r == miopc_pkg::ST_IDLE &&
                           state_nxt == miopc_pkg::ST_RUN;
            pause_cmd_o <= state_nxt == miopc_pkg::ST_PAUSE &&
                           state_r == miopc_pkg::ST_RUN;
            resume_cmd_o <= state_r == miopc_pkg::ST_PAUSE &&
                            state_nxt == miopc_pkg::ST_RUN;
            stop_cmd_o <= stop_low && state_r != miopc_pkg::ST_IDLE; // RL7
        end
    end
    assign work_state_o = state_r;

    ////////////////////////////////////////////////////////////////////////
    // Finish pulse
    logic [miopc_pkg::MS_CNT_W-1:0] fin_r;
    logic fin_done;
    assign fin_done = state_r == miopc_pkg::ST_RUN && job_done_i &&
                      !stop_low;

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            finish_out_o <= 1'b0;
            fin_r <= '0;
        end else if (fin_done) begin
            finish_out_o <= 1'b1; // RL8
            fin_r <= '0;
        end else if (finish_out_o && sif.ms_tick) begin
            if (fin_r == FIN_MS - 1'b1) begin
                finish_out_o <= 1'b0; // RL8
            end else begin
                fin_r <= fin_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            protected_o <= 1'b0;
            laser_on_o <= 1'b0;
            jog_neg_o <= 1'b0;
            jog_pos_o <= 1'b0;
            servo_alarm_o <= '0;
            spare_o <= '0;
            red_out_o <= 1'b0;
            yellow_out_o <= 1'b0;
            green_out_o <= 1'b0;
            beeper_out_o <= 1'b0;
            lift_out_o <= 1'b0;
            vacuum_zone_out_o <= '0;
            vacuum_master_out_o <= 1'b0;
        end else begin
            protected_o <= prot_act; // RL5
            laser_on_o <= laser_req_i && !prot_act; // RL5
            jog_neg_o <= !sif.synced[miopc_pkg::IDX_JOGN]; // RL6
            jog_pos_o <= !sif.synced[miopc_pkg::IDX_JOGP]; // RL6
            servo_alarm_o <= sif.synced[miopc_pkg::IDX_ALARM +:
                                        miopc_pkg::NUM_AXES]; // RL12
            spare_o <= sif.synced[miopc_pkg::IDX_SPARE +:
                                  miopc_pkg::NUM_SPARE]; // RL12
            red_out_o <= red_en_i && red_req_i; // RL9
            yellow_out_o <= yellow_en_i && yellow_req_i; // RL9
            green_out_o <= green_en_i && green_req_i; // RL9
            beeper_out_o <= beep_en_i && beep_req_i; // RL9
            lift_out_o <= lift_io_en_i && (lift_sel_wheel_i ?
                          wheel_lift_req_i : knife_lift_req_i); // RL10
            vacuum_zone_out_o <= vacuum_zone_req_i; // RL11
            vacuum_master_out_o <= vacuum_master_req_i; // RL11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_PRESS_NEEDS_LOW: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) press_r |-> $past(pedal_low, 2)) // RL1
        else $error("press accepted without pedal low");
    AST_IDLE_TO_RUN: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) (state_r == miopc_pkg::ST_IDLE && accept &&
        !prot_act && !stop_low) |=> state_r == miopc_pkg::ST_RUN) // RL2
        else $error("accepted press did not start work");
    AST_GAP_BLOCK: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) (press_r && start_in_gap_r) |=>
        $stable(state_r)) // RL3
        else $error("press inside gap changed state");
    AST_PROT_DISABLED: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) !protect_en_i |=> !protected_o) // RL4
        else $error("protection acted while disabled");
    AST_PROT_LASER: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) protected_o |-> !laser_on_o) // RL5
        else $error("laser on while protected");
    AST_STOP_IDLE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) stop_low |=> state_r == miopc_pkg::ST_IDLE)
        // RL7
        else $error("stop did not end work");
    AST_FIN_RISE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) fin_done |=> finish_out_o) // RL8
        else $error("finish output did not rise");
    AST_LAMP_GATE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) !red_en_i |=> !red_out_o) // RL9
        else $error("red lamp on while disabled");
    AST_LIFT_GATE: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) !lift_io_en_i |=> !lift_out_o) // RL10
        else $error("lift driven outside io mode");
    AST_JOG: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_r) jog_neg_o |-> $past(!sif.synced[2])) // RL6
        else $error("jog request without input low");

    COV_START: cover property (@(posedge core_clk_i) start_cmd_o);
    COV_PAUSE: cover property (@(posedge core_clk_i) pause_cmd_o);
    COV_RESUME: cover property (@(posedge core_clk_i) resume_cmd_o);
    COV_FINISH: cover property (@(posedge core_clk_i) $fell(finish_out_o));
endmodule

/* pkg/miopc_pkg.sv */
// Package of constants and types for the machine I/O panel control block
// How it works
// RL1: A low pedal level is a press, accepted only after 100 ms of continuous low.
// RL2: An accepted press starts work when idle, pauses it when running, resumes it when paused.
// RL3: A new press that begins less than 100 ms after the last accepted press is ignored.
// RL4: The protection input is still synchronised but not acted on while its enable is clear.
// RL5: With protection enabled, a high or floating input suspends work and forces the laser off.
// RL6: The two U jog inputs are active low and request motion while held low.
// RL7: The active-low stop input terminates the running work.
// RL8: The finish output turns on when a job finishes and off one second later.
// RL9: Lamp and beeper outputs are driven only while their function is enabled.
// RL10: The lift output follows knife or wheel lift by selection, only in I/O lift mode.
// RL11: There are eight vacuum-zone outputs and one master vacuum output.
// RL12: There are eight servo alarm inputs and three spare general inputs.
// RL13: Every external input passes a two-stage synchroniser before any other logic.
// RL14: Pedal hold and finish timing use a millisecond tick from a configurable prescaler.
package miopc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_HZ = 1000;
    // Cycles per millisecond tick
    localparam int MS_CYCLES = CLK_HZ / TICK_HZ;
    localparam int PEDAL_HOLD_MS = 100;
    localparam int PEDAL_GAP_MS = 100;
    localparam int FINISH_MS = 1000;
    localparam int MS_CNT_W = 11;
    localparam int PRE_W = 20;
    localparam int NUM_AXES = 8;
    localparam int NUM_ZONES = 8;
    localparam int NUM_SPARE = 3;
    localparam int NUM_SYNC = 16;
    // Positions in the synchronised input vector
    localparam int IDX_PEDAL = 0;
    localparam int IDX_PROT = 1;
    localparam int IDX_JOGN = 2;
    localparam int IDX_JOGP = 3;
    localparam int IDX_STOP = 4;
    localparam int IDX_ALARM = 5;
    localparam int IDX_SPARE = 13;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_PAUSE = 3'h4
    } miopc_state_type;
endpackage

/* pkg/miopc_sync_if.sv */
// Interface carrying raw and synchronised inputs plus the millisecond tick
`timescale 1ns/1ps
interface miopc_sync_if;
    logic [miopc_pkg::NUM_SYNC-1:0] raw;
    logic [miopc_pkg::NUM_SYNC-1:0] synced;
    logic ms_tick;
    modport src (input raw, output synced, output ms_tick);
    modport dst (output raw, input synced, input ms_tick);
endinterface

/* logic/miopc_sync.sv */
// Two-stage input synchronisers for all external inputs
`timescale 1ns/1ps
module miopc_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Signals
    miopc_sync_if.src sif
);
    logic [miopc_pkg::NUM_SYNC-1:0] meta_r;
    logic [miopc_pkg::NUM_SYNC-1:0] sync_r;

    // Active-low inputs idle high, so every bit resets high, protect, alarm and spare included
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= sif.raw; // RL13
            sync_r <= meta_r; // RL13
        end
    end
    assign sif.synced = sync_r;
endmodule

/* logic/miopc_tick.sv */
// Millisecond tick prescaler
`timescale 1ns/1ps
module miopc_tick #(
    parameter logic [miopc_pkg::PRE_W-1:0] DIV =
        miopc_pkg::PRE_W'(miopc_pkg::MS_CYCLES)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Tick output
    miopc_sync_if.src sif
);
    logic [miopc_pkg::PRE_W-1:0] cnt_r;
    logic tick_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == DIV - 1'b1) begin
            cnt_r <= '0;
            tick_r <= 1'b1; // RL14
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end
    assign sif.ms_tick = tick_r;

    AST_TICK_PERIOD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tick_r |=> !tick_r) // RL14
        else $error("tick lasted more than one cycle");
endmodule

/* verification/miopc_panel_model.sv */
// Far-side switches, door contact and drive alarms wired to the panel pins
`timescale 1ns/1ps
module miopc_panel_model (
    // Clock
    input wire logic clk_i,
    // Contact states from the bench, high = actuated
    input wire logic pedal_down_i,
    input wire logic door_open_i,
    input wire logic wire_cut_i,
    input wire logic jog_neg_i,
    input wire logic jog_pos_i,
    input wire logic stop_key_i,
    input wire logic [7:0] alarm_i,
    input wire logic [2:0] spare_i,
    // Pin levels seen by the board
    output logic pedal_pin_o,
    output logic protect_pin_o,
    output logic jog_neg_pin_o,
    output logic jog_pos_pin_o,
    output logic stop_pin_o,
    output logic [7:0] alarm_pin_o,
    output logic [2:0] spare_pin_o
);
    // Idle contacts: pedal, jog and stop pins pulled up through the optocoupler; protect, alarm and spare pins low
    initial begin
        {pedal_pin_o, jog_neg_pin_o, jog_pos_pin_o, stop_pin_o} = 4'hf;
        protect_pin_o = 1'b0;
        alarm_pin_o = 8'h00;
        spare_pin_o = 3'h0;
    end
    always @(posedge clk_i) begin
        pedal_pin_o <= ~pedal_down_i;
        // A cut door wire floats, and the pull-up reads it as open
        protect_pin_o <= door_open_i | wire_cut_i;
        jog_neg_pin_o <= ~jog_neg_i;
        jog_pos_pin_o <= ~jog_pos_i;
        stop_pin_o <= ~stop_key_i;
        alarm_pin_o <= alarm_i;
        spare_pin_o <= spare_i;
    end
endmodule

/* verification/machine_io_panel_control_test.sv */
// Self-checking bench for the machine I/O panel control block
`timescale 1ns/1ps
module machine_io_panel_control_test;
    logic core_clk_i = 1'b0, rstn_i = 1'b0;
    logic pedal_in_n_i, protect_in_i, jog_neg_n_i, jog_pos_n_i, stop_n_i;
    logic [7:0] servo_alarm_in_i;
    logic [2:0] spare_in_i;
    logic protect_en_i = 1'b0, red_en_i = 1'b0, yellow_en_i = 1'b0;
    logic green_en_i = 1'b0, beep_en_i = 1'b0, lift_io_en_i = 1'b0;
    logic lift_sel_wheel_i = 1'b0, job_done_i = 1'b0, red_req_i = 1'b0;
    logic yellow_req_i = 1'b0, green_req_i = 1'b0, beep_req_i = 1'b0;
    logic knife_lift_req_i = 1'b0, wheel_lift_req_i = 1'b0;
    logic laser_req_i = 1'b0, vacuum_master_req_i = 1'b0;
    logic [7:0] vacuum_zone_req_i = 8'h00;
    logic [2:0] work_state_o;
    logic start_cmd_o, pause_cmd_o, resume_cmd_o, stop_cmd_o, protected_o;
    logic laser_on_o, jog_neg_o, jog_pos_o, finish_out_o, red_out_o;
    logic yellow_out_o, green_out_o, beeper_out_o, lift_out_o;
    logic vacuum_master_out_o;
    logic [7:0] servo_alarm_o, vacuum_zone_out_o;
    logic [2:0] spare_o;
    logic pedal_down = 1'b0, door_open = 1'b0, wire_cut = 1'b0;
    logic jog_n = 1'b0, jog_p = 1'b0, stop_key = 1'b0, mon_on = 1'b1;
    logic fin_prev = 1'b0;
    logic [7:0] alarm = 8'h00;
    logic [2:0] spare = 3'h0;
    logic [31:0] r = 32'h0e8043a8;
    logic [3:0] exp_q[$];
    int n_mismatch = 0, n_checks = 0;

    always #4 core_clk_i = ~core_clk_i;

    miopc_top #(.TICK_DIV(20'h00004), .HOLD_MS(11'h003), .GAP_MS(11'h003),
        .FIN_MS(11'h005)) u_miopc_top (.core_clk_i, .rstn_i, .pedal_in_n_i,
        .protect_in_i, .jog_neg_n_i, .jog_pos_n_i, .stop_n_i,
        .servo_alarm_in_i, .spare_in_i, .protect_en_i, .red_en_i,
        .yellow_en_i, .green_en_i, .beep_en_i, .lift_io_en_i,
        .lift_sel_wheel_i, .job_done_i, .red_req_i, .yellow_req_i,
        .green_req_i, .beep_req_i, .knife_lift_req_i, .wheel_lift_req_i,
        .laser_req_i, .vacuum_zone_req_i, .vacuum_master_req_i, .work_state_o,
        .start_cmd_o, .pause_cmd_o, .resume_cmd_o, .stop_cmd_o, .protected_o,
        .laser_on_o, .jog_neg_o, .jog_pos_o, .servo_alarm_o, .spare_o,
        .finish_out_o, .red_out_o, .yellow_out_o, .green_out_o,
        .beeper_out_o, .lift_out_o, .vacuum_zone_out_o, .vacuum_master_out_o);

    miopc_panel_model u_miopc_panel_model (.clk_i(core_clk_i),
        .pedal_down_i(pedal_down), .door_open_i(door_open),
        .wire_cut_i(wire_cut), .jog_neg_i(jog_n), .jog_pos_i(jog_p),
        .stop_key_i(stop_key), .alarm_i(alarm), .spare_i(spare),
        .pedal_pin_o(pedal_in_n_i), .protect_pin_o(protect_in_i),
        .jog_neg_pin_o(jog_neg_n_i), .jog_pos_pin_o(jog_pos_n_i),
        .stop_pin_o(stop_n_i), .alarm_pin_o(servo_alarm_in_i),
        .spare_pin_o(spare_in_i));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // Bounded wait, so a stuck state machine cannot hang the run
    task automatic wait_st(input logic [2:0] e);
        int k;
        k = 0;
        while (work_state_o !== e && k < 80) begin
            cyc(1);
            k++;
        end
        chk("work_state", e, work_state_o);
        if (work_state_o !== e) wrap_up();
    endtask

    task automatic press(input int hold, input logic [3:0] ev);
        if (ev != 4'h0) exp_q.push_back(ev);
        pedal_down <= 1'b1;
        cyc(hold);
        pedal_down <= 1'b0;
        cyc(30);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Event watcher: start, pause, resume pulses and finish rising edge
    always @(posedge core_clk_i) begin
        logic [3:0] got;
        got = {finish_out_o & ~fin_prev, resume_cmd_o, pause_cmd_o,
            start_cmd_o};
        fin_prev <= finish_out_o;
        if (mon_on && got != 4'h0) begin
            if (exp_q.size() == 0) chk("event", 4'h0, got);
            else chk("event", exp_q.pop_front(), got);
        end
    end

    initial begin
        cyc(20);
        chk("reset_state", 3'h1, work_state_o);
        rstn_i <= 1'b1;
        cyc(3);
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            {red_en_i, yellow_en_i, green_en_i, beep_en_i, lift_io_en_i,
                lift_sel_wheel_i} <= r[5:0];
            {red_req_i, yellow_req_i, green_req_i, beep_req_i,
                knife_lift_req_i, wheel_lift_req_i} <= r[11:6];
            vacuum_zone_req_i <= r[19:12];
            vacuum_master_req_i <= r[20];
            laser_req_i <= r[2];
            {jog_n, jog_p} <= r[22:21];
            alarm <= r[30:23];
            spare <= {r[31], r[1:0]};
            cyc(6);
            chk("lamps", {r[5] & r[11], r[4] & r[10], r[3] & r[9],
                r[2] & r[8], r[1] & (r[0] ? r[6] : r[7]), r[19:12], r[20],
                r[2]}, {red_out_o, yellow_out_o, green_out_o, beeper_out_o,
                lift_out_o, vacuum_zone_out_o, vacuum_master_out_o,
                laser_on_o});
            chk("pins", {r[22:21], r[30:23], r[31], r[1:0]}, {jog_neg_o,
                jog_pos_o, servo_alarm_o, spare_o});
        end
        press(6, 4'h0);
        wait_st(3'h1);
        press(40, 4'h1);
        wait_st(3'h2);
        press(40, 4'h2);
        wait_st(3'h4);
        press(40, 4'h4);
        wait_st(3'h2);
        // Second press lands inside the window after the accepted one
        exp_q.push_back(4'h2);
        pedal_down <= 1'b1;
        cyc(20);
        pedal_down <= 1'b0;
        cyc(2);
        press(40, 4'h0);
        wait_st(3'h4);
        press(40, 4'h4);
        wait_st(3'h2);
        laser_req_i <= 1'b1;
        door_open <= 1'b1;
        cyc(10);
        chk("prot_off", {3'h2, 1'b0}, {work_state_o, protected_o});
        mon_on <= 1'b0;
        protect_en_i <= 1'b1;
        cyc(10);
        chk("prot_on", {3'h4, 2'h2}, {work_state_o, protected_o,
            laser_on_o});
        press(40, 4'h0);
        door_open <= 1'b0;
        wire_cut <= 1'b1;
        cyc(10);
        chk("prot_float", {3'h4, 1'b1}, {work_state_o, protected_o});
        wire_cut <= 1'b0;
        cyc(30);
        mon_on <= 1'b1;
        press(40, 4'h4);
        wait_st(3'h2);
        exp_q.push_back(4'h8);
        job_done_i <= 1'b1;
        cyc(1);
        job_done_i <= 1'b0;
        cyc(10);
        chk("finish_on", {3'h1, 1'b1}, {work_state_o, finish_out_o});
        cyc(20);
        chk("finish_off", 1'b0, finish_out_o);
        press(40, 4'h1);
        wait_st(3'h2);
        stop_key <= 1'b1;
        wait_st(3'h1);
        chk("stop_cmd", 1'b1, stop_cmd_o);
        press(40, 4'h0);
        wait_st(3'h1);
        stop_key <= 1'b0;
        cyc(20);
        chk("queue_left", 0, exp_q.size());
        wrap_up();
    end
endmodule
